// *** hw/sec_host.sv ***
// host controller that drives a serial nonvolatile memory with supervisor
// assumes software on a plain strobe port and the device on its own pins
//
// The address map and the plain strobed port were left to the implementer.
module sec_host #(
	parameter bit RST_ACTIVE_HIGH = 1'b0
) (
	input  wire logic                        CORE_CLK,
	input  wire logic                        RESETN,
	input  wire logic [sec_pkg::REG_AW-1:0]  ADDR,
	input  wire logic [sec_pkg::REG_DW-1:0]  WR_DATA,
	input  wire logic                        WR_STB,
	input  wire logic                        RD_STB,
	output logic      [sec_pkg::REG_DW-1:0]  RD_DATA,
	output logic                             CS_N,
	output logic                             SCK,
	output logic                             SI,
	input  wire logic                        SO,
	output logic                             WP_N,
	input  wire logic                        DEV_RST
);

	typedef struct packed {
		sec_pkg::sec_state_t st;
		logic                cs_n;
		logic                sck;
		logic                si;
		logic                wp_n;
		logic                auto_wel;
		logic [15:0]         rd_data;
		logic [2:0]          op;
		logic [2:0]          main_op;
		logic                pend;
		logic [1:0]          cnt;
		logic [8:0]          addr;
		logic [2:0]          nbytes;
		logic [5:0]          bit_cnt;
		logic [7:0]          rx;
		logic [3:0][7:0]     buf_b;
		logic [7:0]          stat_byte;
		logic                refused;
		logic                so_s1;
		logic                so_s2;
		logic                rst_s1;
		logic                rst_s2;
	} sec_host_t;

	sec_host_t s_r;
	sec_host_t s_nxt;
	logic      tick;
	logic      restart;

	// opcode for an operation, ninth address bit folded into bit 3
	function automatic logic [7:0] opcode_of(input logic [2:0] op, input logic a9);
		logic [7:0] oc;
		case (op)
			sec_pkg::OP_SET_LATCH: oc = sec_pkg::set_write_latch_cmd;
			sec_pkg::OP_CLR_LATCH: oc = sec_pkg::clear_write_latch_cmd;
			sec_pkg::OP_STAT_RD:   oc = sec_pkg::status_read_cmd;
			sec_pkg::OP_STAT_WR:   oc = sec_pkg::status_write_cmd;
			sec_pkg::OP_ARRAY_RD:  oc = sec_pkg::ARRAY_RD_CMD;
			default:               oc = sec_pkg::ARRAY_WR_CMD;
		endcase
		if (op == sec_pkg::OP_ARRAY_RD || op == sec_pkg::OP_ARRAY_WR)
			oc[sec_pkg::NINTH_ADDR_POS] = a9;
		return oc;
	endfunction : opcode_of

	// whole bytes in a frame; writes are clipped at the page end
	function automatic logic [2:0] frame_bytes(input logic [2:0] op, input logic [1:0] cnt,
	                                           input logic [8:0] addr);
		logic [2:0] want;
		logic [2:0] room;
		want = 3'(cnt) + 3'h1;
		room = 3'(sec_pkg::PAGE_BYTES) - 3'(addr[1:0]);
		case (op)
			sec_pkg::OP_SET_LATCH, sec_pkg::OP_CLR_LATCH: frame_bytes = 3'h1;
			sec_pkg::OP_STAT_RD, sec_pkg::OP_STAT_WR:     frame_bytes = 3'h2;
			sec_pkg::OP_ARRAY_RD:  frame_bytes = sec_pkg::HDR_ARRAY + want;
			default:               frame_bytes = sec_pkg::HDR_ARRAY + ((want > room) ? room : want);
		endcase
	endfunction : frame_bytes

	// bit of the outgoing frame at a given bit count, most significant first
	function automatic logic tx_bit(input logic [2:0] op, input logic [5:0] idx,
	                                input logic [8:0] addr, input logic [3:0][7:0] b);
		logic [7:0] by;
		logic [2:0] k;
		k = idx[5:3];
		if (k == 3'h0)
			by = opcode_of(op, addr[8]);
		else if (op == sec_pkg::OP_STAT_WR)
			by = b[0];
		else if (k == 3'h1)
			by = addr[7:0];
		else if (op == sec_pkg::OP_ARRAY_WR)
			by = b[2'(k - sec_pkg::HDR_ARRAY)];
		else
			by = 8'h00;
		return by[3'h7 - idx[2:0]];
	endfunction : tx_bit

	// half period enable, realigned when a frame starts from idle
	sec_tick #(
		.HALF (sec_pkg::SCK_HALF_CYC)
	) u_tick (
		.clk     (CORE_CLK),
		.rst_n   (RESETN),
		.restart (restart),
		.tick    (tick)
	);

	assign restart = (s_r.st == sec_pkg::ST_IDLE);

	// next state: software port, pin synchronisers, serial engine
	always_comb begin
		logic [7:0] full;
		logic [2:0] k;
		logic [2:0] sel;
		logic       wr_op;
		full  = {s_r.rx[6:0], s_r.so_s2};
		k     = s_r.bit_cnt[5:3];
		sel   = WR_DATA[sec_pkg::CMD_OP_LSB +: 3];
		wr_op = (sel == sec_pkg::OP_ARRAY_WR || sel == sec_pkg::OP_STAT_WR);
		s_nxt = s_r;
		s_nxt.rd_data = 16'h0000;
		s_nxt.so_s1   = SO;
		s_nxt.so_s2   = s_r.so_s1;
		s_nxt.rst_s1  = DEV_RST;
		s_nxt.rst_s2  = s_r.rst_s1;

		// register writes
		if (WR_STB) begin
			case (ADDR)
				sec_pkg::REG_CMD: begin
					if (WR_DATA[sec_pkg::CMD_GO_BIT]) begin
						if (s_r.st != sec_pkg::ST_IDLE || sel > sec_pkg::OP_ARRAY_WR) begin
							s_nxt.refused = 1'b1;
						end else begin
							s_nxt.main_op = sel;
							s_nxt.cnt     = WR_DATA[sec_pkg::CMD_CNT_LSB +: 2];
							s_nxt.pend    = wr_op && s_r.auto_wel;
							s_nxt.op      = (wr_op && s_r.auto_wel) ? sec_pkg::OP_SET_LATCH : sel;
							s_nxt.nbytes  = frame_bytes(s_nxt.op, s_nxt.cnt, s_r.addr);
							s_nxt.bit_cnt = 6'h00;
							s_nxt.cs_n    = 1'b0;
							s_nxt.si      = tx_bit(s_nxt.op, 6'h00, s_r.addr, s_r.buf_b);
							s_nxt.st      = sec_pkg::ST_LEAD;
						end
					end
				end
				sec_pkg::REG_ADDR: s_nxt.addr = WR_DATA[8:0];
				sec_pkg::REG_CFG: begin
					s_nxt.wp_n     = WR_DATA[sec_pkg::CFG_WP_BIT];
					s_nxt.auto_wel = WR_DATA[sec_pkg::CFG_AUTO_BIT];
				end
				sec_pkg::REG_STAT: begin
					if (WR_DATA[sec_pkg::STAT_REF_BIT])
						s_nxt.refused = 1'b0;
				end
				default: s_nxt.buf_b[ADDR[1:0]] = WR_DATA[7:0];
			endcase
		end

		// register reads, answered in the next cycle
		if (RD_STB) begin
			case (ADDR)
				sec_pkg::REG_CMD: begin
					s_nxt.rd_data[sec_pkg::CMD_OP_LSB +: 3]  = s_r.main_op;
					s_nxt.rd_data[sec_pkg::CMD_CNT_LSB +: 2] = s_r.cnt;
				end
				sec_pkg::REG_ADDR: s_nxt.rd_data[8:0] = s_r.addr;
				sec_pkg::REG_CFG: begin
					s_nxt.rd_data[sec_pkg::CFG_WP_BIT]   = s_r.wp_n;
					s_nxt.rd_data[sec_pkg::CFG_AUTO_BIT] = s_r.auto_wel;
				end
				sec_pkg::REG_STAT: begin
					s_nxt.rd_data[sec_pkg::STAT_BUSY_BIT]     = (s_r.st != sec_pkg::ST_IDLE);
					s_nxt.rd_data[sec_pkg::STAT_RST_BIT]      = (s_r.rst_s2 == RST_ACTIVE_HIGH);
					s_nxt.rd_data[sec_pkg::STAT_REF_BIT]      = s_r.refused;
					s_nxt.rd_data[sec_pkg::STAT_BYTE_LSB +: 8] = s_r.stat_byte;
				end
				default: s_nxt.rd_data[7:0] = s_r.buf_b[ADDR[1:0]];
			endcase
		end

		// serial engine, one step per half period
		if (tick) begin
			case (s_r.st)
				sec_pkg::ST_LEAD, sec_pkg::ST_LO: begin
					// rising edge: device latches SI, host samples SO
					s_nxt.sck = 1'b1;
					s_nxt.rx  = full;
					if (s_r.bit_cnt[2:0] == 3'h7) begin
						if (s_r.op == sec_pkg::OP_ARRAY_RD && k >= sec_pkg::HDR_ARRAY)
							s_nxt.buf_b[2'(k - sec_pkg::HDR_ARRAY)] = full;
						if (s_r.op == sec_pkg::OP_STAT_RD && k == 3'h1) begin
							s_nxt.stat_byte = full;
							s_nxt.buf_b[0]  = full;
						end
					end
					s_nxt.st = sec_pkg::ST_HI;
				end
				sec_pkg::ST_HI: begin
					s_nxt.sck = 1'b0;
					if (s_r.bit_cnt == {3'(s_r.nbytes - 3'h1), 3'h7}) begin
						s_nxt.st = sec_pkg::ST_LAG;
					end else begin
						s_nxt.bit_cnt = s_r.bit_cnt + 6'h01;
						s_nxt.si      = tx_bit(s_r.op, s_r.bit_cnt + 6'h01, s_r.addr, s_r.buf_b);
						s_nxt.st      = sec_pkg::ST_LO;
					end
				end
				sec_pkg::ST_LAG: begin
					s_nxt.cs_n = 1'b1;
					s_nxt.st   = sec_pkg::ST_GAP;
				end
				sec_pkg::ST_GAP: begin
					if (s_r.pend) begin
						// latch frame done, now the write itself in a fresh frame
						s_nxt.pend    = 1'b0;
						s_nxt.op      = s_r.main_op;
						s_nxt.nbytes  = frame_bytes(s_r.main_op, s_r.cnt, s_r.addr);
						s_nxt.bit_cnt = 6'h00;
						s_nxt.cs_n    = 1'b0;
						s_nxt.si      = tx_bit(s_r.main_op, 6'h00, s_r.addr, s_r.buf_b);
						s_nxt.st      = sec_pkg::ST_LEAD;
					end else begin
						s_nxt.st = sec_pkg::ST_IDLE;
					end
				end
				default: s_nxt.st = sec_pkg::ST_IDLE;
			endcase
		end
	end

	// state register
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			s_r          <= '0;
			s_r.st       <= sec_pkg::ST_IDLE;
			s_r.cs_n     <= 1'b1;
			s_r.wp_n     <= sec_pkg::CFG_WP_RST;
			s_r.auto_wel <= sec_pkg::CFG_AUTO_RST;
			s_r.so_s1    <= 1'b1;
			s_r.so_s2    <= 1'b1;
			s_r.rst_s1   <= !RST_ACTIVE_HIGH;  // idle level, no false reset flag after release
			s_r.rst_s2   <= !RST_ACTIVE_HIGH;
		end else begin
			s_r <= s_nxt;
		end
	end

	// pins and read data straight from the state register
	assign RD_DATA = s_r.rd_data;
	assign CS_N    = s_r.cs_n;
	assign SCK     = s_r.sck;
	assign SI      = s_r.si;
	assign WP_N    = s_r.wp_n;

endmodule : sec_host

// *** hw/sec_pkg.sv ***
// constants shared by the serial memory host controller
// assumes a single 25 MHz core clock and a device on four serial pins
package sec_pkg;

	// core clock and serial clock timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int SCK_HALF_NS   = 500;  // least high time, lead, lag and deselect time
	localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// software port geometry
	localparam int REG_AW = 3;
	localparam int REG_DW = 16;

	// register offsets
	localparam logic [2:0] REG_CMD   = 3'h0;
	localparam logic [2:0] REG_ADDR  = 3'h1;
	localparam logic [2:0] REG_CFG   = 3'h2;
	localparam logic [2:0] REG_STAT  = 3'h3;
	localparam logic [2:0] REG_DATA0 = 3'h4;  // data bytes at 4..7

	// command register fields
	localparam int CMD_OP_LSB  = 0;
	localparam int CMD_CNT_LSB = 3;
	localparam int CMD_GO_BIT  = 5;

	// configuration register fields and reset values
	localparam int         CFG_WP_BIT   = 0;
	localparam int         CFG_AUTO_BIT = 1;
	localparam logic       CFG_WP_RST   = 1'b1;  // writes allowed
	localparam logic       CFG_AUTO_RST = 1'b1;  // latch set before each write

	// status register fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_RST_BIT  = 1;
	localparam int STAT_REF_BIT  = 2;
	localparam int STAT_BYTE_LSB = 8;

	// operations that software selects
	localparam logic [2:0] OP_SET_LATCH = 3'h0;
	localparam logic [2:0] OP_CLR_LATCH = 3'h1;
	localparam logic [2:0] OP_STAT_RD   = 3'h2;
	localparam logic [2:0] OP_STAT_WR   = 3'h3;
	localparam logic [2:0] OP_ARRAY_RD  = 3'h4;
	localparam logic [2:0] OP_ARRAY_WR  = 3'h5;

	// device opcodes
	localparam logic [7:0] set_write_latch_cmd   = 8'h06;
	localparam logic [7:0] clear_write_latch_cmd = 8'h04;
	localparam logic [7:0] status_read_cmd       = 8'h05;
	localparam logic [7:0] status_write_cmd      = 8'h01;
	localparam logic [7:0] ARRAY_RD_CMD          = 8'h03;
	localparam logic [7:0] ARRAY_WR_CMD          = 8'h02;
	localparam int         NINTH_ADDR_POS        = 3;

	// frame geometry
	localparam int         PAGE_BYTES = 4;
	localparam logic [2:0] HDR_ARRAY  = 3'h2;

	// serial engine states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LEAD,
		ST_HI,
		ST_LO,
		ST_LAG,
		ST_GAP
	} sec_state_t;

endpackage : sec_pkg

// *** hw/sec_tick.sv ***
// half period enable for the serial clock
// assumes restart comes from logic on the same clock
module sec_tick #(
	parameter int HALF = 13
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic restart,
	output logic      tick
);

	logic [7:0] cnt_r;

	// count down one half period, reload on restart
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 8'h00;
			tick  <= 1'b0;
		end else if (restart || cnt_r == 8'h00) begin
			cnt_r <= 8'(HALF - 1);
			tick  <= !restart;
		end else begin
			cnt_r <= cnt_r - 8'h01;
			tick  <= 1'b0;
		end
	end

endmodule : sec_tick

// *** test/sec_dev.sv ***
// behavioural serial memory device with supervisor output
// assumes mode 0 frames from the host controller
module sec_dev #(
	parameter int WR_NS  = 30000,
	parameter int WD0_NS = 1400000000,
	parameter int WD1_NS = 600000000,
	parameter int WD2_NS = 200000000
) (
	input  wire logic cs_n,
	input  wire logic sck,
	input  wire logic si,
	input  wire logic wp_n,
	input  wire logic trip,
	output logic      so,
	output logic      rst_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]      mem [512];
	logic [7:0]      op, sh, osh, st;
	logic [8:0]      adr;
	logic [3:0][7:0] wb;
	logic [3:0]      wm;
	logic            write_latch_flag, write_in_progress_flag, oen, so_r;
	logic            wd_out = 1'b0;
	int              cnt;
	// power-up: idle, latch clear, array preset
	initial begin
		{write_latch_flag, write_in_progress_flag, oen, st} = '0;
		for (int i = 0; i < 512; i++) mem[i] = 8'(i) ^ 8'hA5;
	end
	// falling select opens a frame
	always @(negedge cs_n) begin
		cnt = 0;
		oen = 0;
		wd_out = 0;
		disable wd_run;
	end
	// watchdog: select must fall again within the chosen timeout
	always begin : wd_run
		if (st[5:4] == 2'b11) begin
			@(st);
		end else begin
			#(st[5:4] == 2'b00 ? WD0_NS : st[5:4] == 2'b01 ? WD1_NS : WD2_NS);
			wd_out = 1;
			@(negedge cs_n);
		end
	end
	// protected region of the array for the current protect field
	function automatic logic locked(input logic [8:0] a);
		return (st[3:2] == 2'b11) || (st[3:2] == 2'b10 && a[8]) || (st[3:2] == 2'b01 && a[8:7] == 2'b11);
	endfunction : locked
	// bits taken on the rising clock
	always @(posedge sck) begin
		if (!cs_n) begin
			sh = {sh[6:0], si};
			cnt++;
			if (cnt == 8) op = sh;
			if (cnt == 8 && sh == 8'h05) begin
				osh = write_in_progress_flag ? 8'hFF : {st[7:2], write_latch_flag, 1'b0};
				oen = 1;
			end
			if (cnt == 16) begin
				adr = {op[3], sh};
				wm = '0;
			end
			if (cnt >= 16 && cnt % 8 == 0 && {op[7:4], op[2:0]} == 7'h03) begin
				adr = adr + 9'(cnt > 16);
				osh = mem[adr];
				oen = 1;
			end
			if (cnt > 16 && cnt % 8 == 0) begin
				wb[adr[1:0] + 2'(cnt / 8 - 3)] = sh;
				wm[adr[1:0] + 2'(cnt / 8 - 3)] = 1'b1;
			end
		end
	end
	// output bits change after the falling clock
	always @(negedge sck) begin
		if (oen) begin
			so_r = osh[7];
			osh = osh << 1;
		end
	end
	assign so = (!cs_n && oen) ? so_r : 1'b1;
	// deselect commits what ended on a whole byte
	always @(posedge cs_n) begin
		if (cnt == 8 && op == 8'h06) write_latch_flag = 1;
		if (cnt == 8 && op == 8'h04) write_latch_flag = 0;
		if (write_latch_flag && wp_n && !write_in_progress_flag && cnt == 16 && op == 8'h01) begin
			st = sh;
			write_in_progress_flag = 1;
		end
		if (write_latch_flag && wp_n && !write_in_progress_flag && cnt inside {24, 32, 40, 48} && {op[7:4], op[2:0]} == 7'h02) begin
			for (int i = 0; i < 4; i++) if (wm[i] && !locked({adr[8:2], 2'(i)})) mem[{adr[8:2], 2'(i)}] = wb[i];
			write_in_progress_flag = 1;
		end
		oen = 0;
	end
	// self-timed write, then the latch drops
	always @(posedge write_in_progress_flag) begin
		#(WR_NS);
		write_in_progress_flag = 0;
		write_latch_flag = 0;
	end
	always @(negedge wp_n) write_latch_flag = 0;
	assign rst_out = trip || wd_out;
endmodule : sec_dev

// *** test/sec_host_assertions.sv ***
// port checks for the serial memory host controller
// assumes a bind onto the controller and one core clock
module sec_host_chk (
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire logic CS_N,
	input wire logic SCK,
	input wire logic SI
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [6:0] cnt_r;
	logic [7:0] op_r;
	logic       sck_r;
	wire        rise = SCK && !sck_r;
	// clock rises per frame and the opcode byte
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			{cnt_r, op_r, sck_r} <= '0;
		end else begin
			sck_r <= SCK;
			cnt_r <= CS_N ? 7'h00 : cnt_r + 7'(rise);
			if (rise && cnt_r < 7'h08) op_r <= {op_r[6:0], SI};
		end
	end
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RESETN);
	sequence s_lead; !SCK [*8]; endsequence
	sequence s_end; $rose(CS_N); endsequence
	property p_lead; $fell(CS_N) |-> s_lead; endproperty
	a_lead: assert property (p_lead) else $error("lead");
	property p_idle; CS_N |-> !SCK; endproperty
	a_idle: assert property (p_idle) else $error("idle clock");
	property p_hold; SCK && $past(SCK) |-> $stable(SI); endproperty
	a_hold: assert property (p_hold) else $error("data hold");
	property p_gap; s_end |-> CS_N [*8]; endproperty
	a_gap: assert property (p_gap) else $error("gap");
	property p_byte; s_end |-> cnt_r[2:0] == 3'h0; endproperty
	a_byte: assert property (p_byte) else $error("bytes");
	property p_latch; s_end ##0 (op_r inside {8'h06, 8'h04}) |-> cnt_r == 7'h08; endproperty
	a_latch: assert property (p_latch) else $error("latch len");
	property p_wr; s_end ##0 ({op_r[7:4], op_r[2:0]} == 7'h02) |-> cnt_r inside {7'h18, 7'h20, 7'h28, 7'h30};
	endproperty
	a_wr: assert property (p_wr) else $error("write len");
	property p_op; s_end |-> op_r inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0A, 8'h0B}; endproperty
	a_op: assert property (p_op) else $error("opcode");
endmodule : sec_host_chk
bind sec_host sec_host_chk u_chk (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .CS_N(CS_N), .SCK(SCK), .SI(SI));

// *** test/tb_top.sv ***
// self-checking bench for the serial memory host controller
// assumes the behavioural device model on the serial pins
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        CORE_CLK = '0, RESETN = '0, WR_STB = '0, RD_STB = '0, trip = '0;
	logic [2:0]  ADDR = '0;
	logic [15:0] WR_DATA = '0, RD_DATA, rv;
	logic        CS_N, SCK, SI, SO, WP_N, DEV_RST;
	int          num_errors = 0, compares = 0, cyc = 0;
	always #20 CORE_CLK = ~CORE_CLK;
	sec_host #(.RST_ACTIVE_HIGH(1'b1)) DUT (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .ADDR(ADDR), .WR_DATA(WR_DATA),
		.WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .CS_N(CS_N), .SCK(SCK), .SI(SI), .SO(SO),
		.WP_N(WP_N), .DEV_RST(DEV_RST));
	sec_dev u_dev (.cs_n(CS_N), .sck(SCK), .si(SI), .wp_n(WP_N), .trip(trip), .so(SO), .rst_out(DEV_RST));
	// bus cycles and comparison
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge CORE_CLK);
		ADDR <= a;
		WR_DATA <= d;
		WR_STB <= 1'b1;
		@(posedge CORE_CLK);
		WR_STB <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a);
		@(posedge CORE_CLK);
		ADDR <= a;
		RD_STB <= 1'b1;
		@(posedge CORE_CLK);
		RD_STB <= 1'b0;
		#1 rv = RD_DATA;
	endtask : rd
	task automatic chk(input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %0t exp %h got %h", $time, e, g);
		end
	endtask : chk
	// start a frame and wait until the controller is idle
	task automatic run(input logic [2:0] op, input logic [1:0] n);
		wr(sec_pkg::REG_CMD, {10'h000, 1'b1, n, op});
		rd(sec_pkg::REG_STAT);
		for (int i = 0; i < 5000 && rv[0] !== 1'b0; i++) rd(sec_pkg::REG_STAT);
	endtask : run
	task automatic sr();
		run(sec_pkg::OP_STAT_RD, 2'h0);
	endtask : sr
	task automatic idle();
		for (int i = 0; i < 20 && rv[8] !== 1'b0; i++) sr();
	endtask : idle
	task automatic chkd(input logic [31:0] e);
		for (int i = 0; i < 4; i++) begin
			rd(sec_pkg::REG_DATA0 + 3'(i));
			chk(16'(e[31 - 8 * i -: 8]), 16'(rv[7:0]));
		end
	endtask : chkd
	task automatic t_latch();
		run(sec_pkg::OP_SET_LATCH, 2'h0);
		sr();
		chk(16'h0200, rv & 16'hFF07);
		run(sec_pkg::OP_CLR_LATCH, 2'h0);
		sr();
		chk(16'h0000, rv & 16'hFF07);
		$display("latch test done");
	endtask : t_latch
	task automatic t_page();
		for (int i = 0; i < 4; i++) wr(3'(4 + i), 16'(8'h11 * (i + 1)));
		wr(sec_pkg::REG_ADDR, 16'h01FC);
		run(sec_pkg::OP_ARRAY_WR, 2'h3);
		sr();
		chk(16'h0001, 16'(rv[8]));
		idle();
		wr(sec_pkg::REG_ADDR, 16'h01FE);
		run(sec_pkg::OP_ARRAY_RD, 2'h3);
		chkd(32'h3344A5A4);
		wr(sec_pkg::REG_ADDR, 16'h00A2);
		run(sec_pkg::OP_ARRAY_WR, 2'h3);
		sr();
		idle();
		wr(sec_pkg::REG_ADDR, 16'h00A0);
		run(sec_pkg::OP_ARRAY_RD, 2'h3);
		chkd(32'h05043344);
		$display("page test done");
	endtask : t_page
	task automatic t_guard();
		wr(sec_pkg::REG_CFG, 16'h0001);
		run(sec_pkg::OP_SET_LATCH, 2'h0);
		wr(sec_pkg::REG_CFG, 16'h0000);
		wr(sec_pkg::REG_CFG, 16'h0001);
		sr();
		chk(16'h0000, 16'(rv[9]));
		wr(sec_pkg::REG_ADDR, 16'h0010);
		run(sec_pkg::OP_ARRAY_WR, 2'h0);
		run(sec_pkg::OP_ARRAY_RD, 2'h0);
		chkd(32'hB5043344);
		wr(sec_pkg::REG_CFG, 16'h0003);
		wr(sec_pkg::REG_DATA0, 16'h0030);
		run(sec_pkg::OP_STAT_WR, 2'h0);
		sr();
		idle();
		chk(16'h3000, rv & 16'hFF00);
		$display("guard test done");
	endtask : t_guard
	task automatic t_misc();
		wr(sec_pkg::REG_CMD, 16'h0026);
		rd(sec_pkg::REG_STAT);
		chk(16'h0004, rv & 16'h0007);
		wr(sec_pkg::REG_STAT, 16'h0004);
		trip <= 1'b1;
		repeat (4) @(posedge CORE_CLK);
		rd(sec_pkg::REG_STAT);
		chk(16'h0002, rv & 16'h0007);
		trip <= 1'b0;
		repeat (4) @(posedge CORE_CLK);
		rd(sec_pkg::REG_STAT);
		chk(16'h0000, rv & 16'h0007);
		$display("misc test done");
	endtask : t_misc
	task automatic stop_test();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	// hang guard
	always @(posedge CORE_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			stop_test();
		end
	end
	// reset, then the scenarios
	initial begin
		repeat (16) @(posedge CORE_CLK);
		RESETN <= 1'b1;
		t_latch();
		t_page();
		t_guard();
		t_misc();
		stop_test();
	end
endmodule : tb_top
